/* serial_req_pkg.sv */
// Constants, register map helpers and state types of the serial request validator
package serial_req_pkg;
   // Function codes
   localparam logic [7:0] FN_READ = 8'h03;
   localparam logic [7:0] FN_LOOP = 8'h08;
   localparam logic [7:0] FN_WRITE = 8'h10;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   // Error codes
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_FUNC = 8'h01;
   localparam logic [7:0] ERR_REG = 8'h02;
   localparam logic [7:0] ERR_QTY = 8'h03;
   localparam logic [7:0] ERR_DATA = 8'h21;
   localparam logic [7:0] ERR_MODE = 8'h22;
   localparam logic [7:0] ERR_UV = 8'h23;
   localparam logic [7:0] ERR_BUSY = 8'h24;
   // Addressing and counts
   localparam logic [7:0] BCAST_ADDR = 8'h00;
   localparam logic [15:0] BCAST_START_A = 16'h0001;
   localparam logic [15:0] BCAST_START_B = 16'h0002;
   localparam logic [15:0] QTY_MIN = 16'h0001;
   localparam logic [15:0] QTY_MAX = 16'h0010;
   localparam int QTY_LOOP = 16;
   localparam logic [4:0] GAP_LIMIT_BITS = 5'h18;
   localparam logic [7:0] LEN_MIN = 8'h04;
   localparam logic [7:0] LEN_FIXED = 8'h08;
   localparam logic [7:0] LEN_WR_HDR = 8'h09;
   localparam logic [7:0] IDX_FUNC = 8'h01;
   localparam logic [7:0] IDX_START_HI = 8'h02;
   localparam logic [7:0] IDX_START_LO = 8'h03;
   localparam logic [7:0] IDX_QTY_HI = 8'h04;
   localparam logic [7:0] IDX_QTY_LO = 8'h05;
   localparam logic [7:0] IDX_BC = 8'h06;
   localparam logic [7:0] IDX_DATA = 8'h07;
   localparam logic [2:0] TX_LAST = 3'h4;
   // CRC-16, reflected polynomial
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   // Register map
   localparam logic [15:0] CTRL_FIRST = 16'h0001;
   localparam logic [15:0] CTRL_LAST = 16'h000F;
   localparam logic [15:0] MON_FIRST = 16'h0010;
   localparam logic [15:0] MON_LAST = 16'h003F;
   localparam logic [15:0] PAR_FIRST = 16'h0100;
   localparam logic [15:0] PAR_LAST = 16'h05FF;
   localparam logic [15:0] ENTER_NVM = 16'h0900;
   localparam logic [15:0] ENTER_RAM = 16'h0910;
   localparam logic [15:0] INIT_PARAM_FIRST = 16'h0101;
   localparam logic [15:0] INIT_PARAM_LAST = 16'h0106;
   localparam logic [15:0] MOTOR_PATTERN_PARAM = 16'h0302;

   typedef enum logic [1:0] {S_IDLE, S_RECV, S_TX} phase_t;

   function automatic logic is_param(input logic [15:0] a);
      return a >= PAR_FIRST && a <= PAR_LAST;
   endfunction
   function automatic logic is_enter(input logic [15:0] a);
      return a == ENTER_NVM || a == ENTER_RAM;
   endfunction
   function automatic logic is_read_only(input logic [15:0] a);
      return a >= MON_FIRST && a <= MON_LAST;
   endfunction
   function automatic logic reg_exists(input logic [15:0] a);
      return (a >= CTRL_FIRST && a <= MON_LAST) || is_param(a) || is_enter(a);
   endfunction
   function automatic logic nvm_allowed(input logic [15:0] a);
      return (a >= INIT_PARAM_FIRST && a <= INIT_PARAM_LAST) || a == MOTOR_PATTERN_PARAM;
   endfunction
endpackage

/* crc16_step.sv */
// One-byte CRC-16 update, one cycle, combinational
`timescale 1ns/1ps
module crc16_step import serial_req_pkg::*; (
   // Running value and new byte
   input wire logic [15:0] crc_in,
   input wire logic [7:0] data,
   // Updated value
   output logic [15:0] crc_out
);
   logic [15:0] stage [0:8];

   assign stage[0] = crc_in ^ {8'h00, data};
   for (genvar k = 0; k < 8; k++) begin : g_bit
      assign stage[k + 1] = stage[k][0] ? ((stage[k] >> 1) ^ CRC_POLY) : (stage[k] >> 1);
   end
   assign crc_out = stage[8];
endmodule // crc16_step

/* serial_req_validator.sv */
// Request checker of the serial slave: frame screening, error codes, exception reply
`timescale 1ns/1ps
// How it works
// - Unknown function code answers 01H
// - Missing register number answers 02H
// - Broadcast start must be 0001H or 0002H
// - Register count outside 1..16 answers 03H
// - Write byte count must equal twice count
// - Out-of-bounds written data answers 21H
// - Invalid parameter setting answers 21H
// - Running drive refuses parameter, apply writes: 22H
// - Memory defect allows few parameters, else 22H
// - Writing read-only register answers 22H
// - Bus undervoltage refuses parameter, apply writes: 23H
// - Parameter write while processing answers 24H
// - Line or CRC error: silent discard
// - Gap over 24 bits: silent discard
// - Wrong length for 03H, 08H or 10H: silent discard
// - Reading apply registers answers 02H
module serial_req_validator import serial_req_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Receiver
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_err,
   input wire logic bit_tick,
   input wire logic frame_end,
   input wire logic [7:0] my_addr,
   // Drive state
   input wire logic drive_running,
   input wire logic dc_bus_low_alarm,
   input wire logic nvm_defect_alarm,
   input wire logic param_busy,
   // Value bounds for lim_addr
   output logic [15:0] lim_addr,
   input wire logic [15:0] lim_lo,
   input wire logic [15:0] lim_hi,
   input wire logic setting_ok,
   // Exception reply
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready,
   // Accepted command
   output logic cmd_ok,
   output logic cmd_bcast,
   output logic [7:0] cmd_func,
   output logic [15:0] cmd_start,
   output logic [15:0] cmd_qty
);
   typedef struct packed {
      phase_t phase;
      logic [7:0] cnt;
      logic [4:0] gap;
      logic bad;
      logic [7:0] addr;
      logic [7:0] func;
      logic [15:0] start;
      logic [15:0] qty;
      logic [7:0] bc;
      logic [7:0] hold;
      logic [7:0] widx;
      logic [7:0] err;
      logic [15:0] crc;
      logic [2:0] txi;
      logic [7:0] txb;
      logic [15:0] txcrc;
      logic ok;
   } state_t;

   state_t s, next_s;
   logic [15:0] crc_rx_next, crc_tx_next;
   logic [15:0] word;
   logic [7:0] hdr_code, word_code, code;
   logic len_ok, keep;

   crc16_step u_crc_rx (
      .crc_in (s.phase == S_IDLE ? CRC_INIT : s.crc),
      .data (rx_byte),
      .crc_out (crc_rx_next)
   );
   crc16_step u_crc_tx (
      .crc_in (s.txcrc),
      .data (s.txb),
      .crc_out (crc_tx_next)
   );

   assign word = {s.hold, rx_byte};
   assign lim_addr = s.start + {8'h00, s.widx};

   // Header checks in priority order
   function automatic logic [7:0] header_check(input state_t f);
      logic regbad;
      logic [15:0] a;
      regbad = 1'b0;
      a = 16'h0000;
      if (f.func != FN_READ && f.func != FN_LOOP && f.func != FN_WRITE) begin
         return ERR_FUNC;
      end
      if (f.func == FN_LOOP) begin
         return ERR_NONE;
      end
      if (f.addr == BCAST_ADDR && f.start != BCAST_START_A && f.start != BCAST_START_B) begin
         regbad = 1'b1;
      end
      for (int i = 0; i < QTY_LOOP; i++) begin
         a = f.start + 16'(i);
         if (16'(i) < f.qty && (!reg_exists(a) || (f.func == FN_READ && is_enter(a)))) begin
            regbad = 1'b1;
         end
      end
      if (regbad) begin
         return ERR_REG;
      end
      if (f.qty < QTY_MIN || f.qty > QTY_MAX) begin
         return ERR_QTY;
      end
      if (f.func == FN_WRITE && {8'h00, f.bc} != {f.qty[14:0], 1'b0}) begin
         return ERR_QTY;
      end
      return ERR_NONE;
   endfunction

   // Per-word write checks; state alarms before data so no value slips in
   always_comb begin
      word_code = ERR_NONE;
      if (is_read_only(lim_addr)) begin
         word_code = ERR_MODE;
      end else if ((is_param(lim_addr) || is_enter(lim_addr)) && drive_running) begin
         word_code = ERR_MODE;
      end else if ((is_param(lim_addr) || is_enter(lim_addr)) && dc_bus_low_alarm) begin
         word_code = ERR_UV;
      end else if (is_param(lim_addr) && nvm_defect_alarm && !nvm_allowed(lim_addr)) begin
         word_code = ERR_MODE;
      end else if (is_param(lim_addr) && param_busy) begin
         word_code = ERR_BUSY;
      end else if (word < lim_lo || word > lim_hi || (is_param(lim_addr) && !setting_ok)) begin
         word_code = ERR_DATA;
      end
   end

   assign hdr_code = header_check(s);
   assign code = (hdr_code != ERR_NONE) ? hdr_code : s.err;
   assign len_ok = s.cnt >= LEN_MIN &&
      (s.func == FN_WRITE ? s.cnt == LEN_WR_HDR + s.bc :
       (s.func == FN_READ || s.func == FN_LOOP) ? s.cnt == LEN_FIXED : 1'b1);
   assign keep = !s.bad && len_ok && s.crc == 16'h0000 &&
      (s.addr == my_addr || s.addr == BCAST_ADDR);

   always_comb begin
      next_s = s;
      next_s.ok = 1'b0;
      case (s.phase)
         S_IDLE: begin
            if (rx_valid) begin
               next_s = '0;
               next_s.phase = S_RECV;
               next_s.cnt = 8'h01;
               next_s.addr = rx_byte;
               next_s.crc = crc_rx_next;
               next_s.bad = rx_err;
            end
         end
         S_RECV: begin
            if (rx_valid) begin
               next_s.crc = crc_rx_next;
               next_s.gap = 5'h00;
               next_s.bad = s.bad | rx_err | (s.gap > GAP_LIMIT_BITS);
               if (s.cnt != 8'hFF) begin
                  next_s.cnt = s.cnt + 8'h01;
               end
               case (s.cnt)
                  IDX_FUNC: next_s.func = rx_byte;
                  IDX_START_HI: next_s.start[15:8] = rx_byte;
                  IDX_START_LO: next_s.start[7:0] = rx_byte;
                  IDX_QTY_HI: next_s.qty[15:8] = rx_byte;
                  IDX_QTY_LO: next_s.qty[7:0] = rx_byte;
                  IDX_BC: next_s.bc = rx_byte;
                  default: begin
                     if (s.func == FN_WRITE && s.cnt >= IDX_DATA && s.cnt < IDX_DATA + s.bc) begin
                        if (s.cnt[0]) begin
                           next_s.hold = rx_byte;
                        end else begin
                           next_s.widx = s.widx + 8'h01;
                           if (s.err == ERR_NONE) begin
                              next_s.err = word_code;
                           end
                        end
                     end
                  end
               endcase
            end else if (frame_end) begin
               next_s.phase = S_IDLE;
               next_s.err = code;
               if (keep && code == ERR_NONE) begin
                  next_s.ok = 1'b1;
               end else if (keep && s.addr != BCAST_ADDR) begin
                  next_s.phase = S_TX;
                  next_s.txi = 3'h0;
                  next_s.txb = s.addr;
                  next_s.txcrc = CRC_INIT;
               end
            end else if (bit_tick && s.gap <= GAP_LIMIT_BITS) begin
               // Saturates one past the limit; only the compare matters
               next_s.gap = s.gap + 5'h01;
            end
         end
         S_TX: begin
            if (tx_ready) begin
               next_s.txi = s.txi + 3'h1;
               // flagged function, code, CRC low then high
               case (s.txi)
                  3'h0: next_s.txb = s.func | EXC_FLAG;
                  3'h1: next_s.txb = s.err;
                  3'h2: next_s.txb = crc_tx_next[7:0];
                  3'h3: next_s.txb = s.txcrc[15:8];
                  default: next_s.phase = S_IDLE;
               endcase
               if (s.txi <= 3'h2) begin
                  next_s.txcrc = crc_tx_next;
               end
            end
         end
         default: next_s.phase = S_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Half duplex: characters arriving during a reply are not seen
   assign tx_valid = (s.phase == S_TX);
   assign tx_byte = s.txb;
   assign cmd_ok = s.ok;
   assign cmd_bcast = (s.addr == BCAST_ADDR);
   assign cmd_func = s.func;
   assign cmd_start = s.start;
   assign cmd_qty = s.qty;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_func_code: assert property (
      s.phase == S_RECV && frame_end && !rx_valid && keep && s.addr != BCAST_ADDR &&
      s.func != FN_READ && s.func != FN_LOOP && s.func != FN_WRITE
      |=> tx_valid && s.err == ERR_FUNC) else $error("bad function not answered 01H");
   chk_enter_read: assert property (
      tx_valid && s.func == FN_READ && is_enter(s.start) |-> s.err == ERR_REG)
      else $error("read of apply register not 02H");
   chk_bcast_start: assert property (
      cmd_ok && cmd_bcast && cmd_func != FN_LOOP
      |-> cmd_start == BCAST_START_A || cmd_start == BCAST_START_B)
      else $error("broadcast accepted at bad start");
   chk_qty_range: assert property (
      cmd_ok && cmd_func != FN_LOOP |-> cmd_qty >= QTY_MIN && cmd_qty <= QTY_MAX)
      else $error("count outside 1..16 accepted");
   chk_byte_count: assert property (
      tx_valid && s.func == FN_WRITE && s.bc[0] |-> s.err == ERR_REG || s.err == ERR_QTY)
      else $error("odd byte count not refused");
   chk_run_write: assert property (
      s.phase == S_RECV && rx_valid && s.func == FN_WRITE && s.cnt >= IDX_DATA &&
      s.cnt < IDX_DATA + s.bc && !s.cnt[0] && s.err == ERR_NONE && drive_running &&
      is_param(lim_addr) |=> s.err == ERR_MODE) else $error("write while running kept");
   chk_uv_write: assert property (
      s.phase == S_RECV && rx_valid && s.func == FN_WRITE && s.cnt >= IDX_DATA &&
      s.cnt < IDX_DATA + s.bc && !s.cnt[0] && s.err == ERR_NONE && !drive_running &&
      dc_bus_low_alarm && is_enter(lim_addr) |=> s.err == ERR_UV)
      else $error("apply write in undervoltage kept");
   chk_line_drop: assert property (
      s.phase == S_RECV && frame_end && !rx_valid && s.bad |=> !tx_valid && !cmd_ok)
      else $error("damaged frame answered");
   chk_late_char: assert property (
      s.phase == S_RECV && rx_valid && s.gap > GAP_LIMIT_BITS |=> s.bad)
      else $error("late character not marked");
   chk_len_drop: assert property (
      s.phase == S_RECV && frame_end && !rx_valid && s.func == FN_READ && s.cnt != LEN_FIXED
      |=> !tx_valid && !cmd_ok) else $error("bad length answered");
   chk_exc_reply: assert property (
      tx_valid && s.txi == 3'h1 |-> tx_byte == (s.func | EXC_FLAG))
      else $error("reply function not flagged");
   chk_bcast_quiet: assert property (
      tx_valid |-> s.addr != BCAST_ADDR) else $error("broadcast answered");
endmodule // serial_req_validator

/* serial_master_model.sv */
// Bus master model: sends request frames and takes exception replies
`timescale 1ns/1ps
module serial_master_model (
   // Clock
   input wire logic clk,
   // Request characters
   output logic rx_valid,
   output logic [7:0] rx_byte,
   output logic rx_err,
   output logic bit_tick,
   output logic frame_end,
   // Exception reply
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   output logic tx_ready
);
   logic [7:0] got[$];

   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'hA5;
      rx_err = 1'b0;
      bit_tick = 1'b0;
      frame_end = 1'b0;
      tx_ready = 1'b0;
   end

   // Stalls at random, so each reply byte must stand until taken
   always @(posedge clk) begin
      tx_ready <= 1'($urandom % 2);
      if (tx_valid && tx_ready)
         got.push_back(tx_byte);
   end

   task automatic send(input logic [7:0] f[$], input int err_at, input int gap);
      for (int i = 0; i < f.size(); i++) begin
         repeat (i == 2 ? gap : (i == 0 ? 0 : $urandom % 13)) begin
            @(posedge clk);
            bit_tick <= 1'b1;
         end
         @(posedge clk);
         bit_tick <= 1'b0;
         rx_valid <= 1'b1;
         rx_byte <= f[i];
         rx_err <= (i == err_at);
         @(posedge clk);
         rx_valid <= 1'b0;
         // Unqualified rx_byte never repeats the last value; rx_err goes random
         rx_byte <= ~f[i];
         rx_err <= 1'($urandom % 2);
      end
      @(posedge clk);
      frame_end <= 1'b1;
      @(posedge clk);
      frame_end <= 1'b0;
   endtask
endmodule // serial_master_model

/* tb.sv */
// Self-checking bench of the serial request validator
`timescale 1ns/1ps
module tb;
   import serial_req_pkg::*;
   localparam logic [7:0] bad_fn [5] = '{8'h00, 8'h01, 8'h04, 8'h83, 8'hFF};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] my_addr = 8'h1F;
   logic drive_running = 1'b0;
   logic dc_bus_low_alarm = 1'b0;
   logic nvm_defect_alarm = 1'b0;
   logic param_busy = 1'b0;
   logic [15:0] lim_lo = 16'h0000;
   logic [15:0] lim_hi = 16'h0FFF;
   logic setting_ok = 1'b1;
   logic rx_valid, rx_err, bit_tick, frame_end, tx_ready, tx_valid, cmd_ok, cmd_bcast;
   logic [7:0] rx_byte, tx_byte, cmd_func;
   logic [15:0] lim_addr, cmd_start, cmd_qty;
   int fail_count = 0;
   int num_checks = 0;

   always #2 clk = ~clk;

   serial_req_validator i_serial_req_validator (.clk(clk), .rst_b(rst_b),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_err(rx_err), .bit_tick(bit_tick),
      .frame_end(frame_end), .my_addr(my_addr), .drive_running(drive_running),
      .dc_bus_low_alarm(dc_bus_low_alarm), .nvm_defect_alarm(nvm_defect_alarm),
      .param_busy(param_busy), .lim_addr(lim_addr), .lim_lo(lim_lo), .lim_hi(lim_hi),
      .setting_ok(setting_ok), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
      .cmd_ok(cmd_ok), .cmd_bcast(cmd_bcast), .cmd_func(cmd_func), .cmd_start(cmd_start),
      .cmd_qty(cmd_qty));

   serial_master_model i_serial_master_model (.clk(clk), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .rx_err(rx_err), .bit_tick(bit_tick), .frame_end(frame_end),
      .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));

   function automatic logic [15:0] crc16(input logic [7:0] f[$]);
      logic [15:0] c;
      c = CRC_INIT;
      foreach (f[i]) begin
         c ^= {8'h00, f[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      end
      return c;
   endfunction

   // Error code a request earns; 00 means accepted
   function automatic logic [7:0] exp_code(input logic [7:0] fn, input logic [15:0] st, q, w,
                                           input logic [7:0] bc, input logic bc0);
      logic [15:0] a;
      logic par;
      logic ent;
      if (fn != FN_READ && fn != FN_LOOP && fn != FN_WRITE) return ERR_FUNC;
      if (fn == FN_LOOP) return ERR_NONE;
      for (int i = 0; i < q && i < 16; i++) begin
         a = st + 16'(i);
         ent = a == ENTER_NVM || a == ENTER_RAM;
         par = a >= PAR_FIRST && a <= PAR_LAST;
         if (!((a >= CTRL_FIRST && a <= MON_LAST) || par || ent)) return ERR_REG;
         if (fn == FN_READ && ent) return ERR_REG;
      end
      if (bc0 && st != BCAST_START_A && st != BCAST_START_B) return ERR_REG;
      if (q < QTY_MIN || q > QTY_MAX) return ERR_QTY;
      if (fn == FN_WRITE && {8'h00, bc} != q << 1) return ERR_QTY;
      if (fn == FN_READ) return ERR_NONE;
      for (int i = 0; i < q; i++) begin
         a = st + 16'(i);
         par = a >= PAR_FIRST && a <= PAR_LAST;
         ent = a == ENTER_NVM || a == ENTER_RAM;
         if (a >= MON_FIRST && a <= MON_LAST) return ERR_MODE;
         if ((par || ent) && drive_running) return ERR_MODE;
         if ((par || ent) && dc_bus_low_alarm) return ERR_UV;
         if (par && nvm_defect_alarm && !((a >= INIT_PARAM_FIRST && a <= INIT_PARAM_LAST)
             || a == MOTOR_PATTERN_PARAM)) return ERR_MODE;
         if (par && param_busy) return ERR_BUSY;
         if (w < lim_lo || w > lim_hi || (par && !setting_ok)) return ERR_DATA;
      end
      return ERR_NONE;
   endfunction

   task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic set_state(input bit r, uv, nvm, busy, ok, input logic [15:0] hi,
                            lo = 16'h0000);
      @(posedge clk);
      drive_running <= r;
      dc_bus_low_alarm <= uv;
      nvm_defect_alarm <= nvm;
      param_busy <= busy;
      setting_ok <= ok;
      lim_hi <= hi;
      lim_lo <= lo;
   endtask

   // One request, then acceptance and reply are compared
   task automatic run(input logic [7:0] ad, fn, input logic [15:0] st, q, w = 16'h0005,
                      input logic [7:0] bc = 8'h02, input int extra = 0, err_at = -1,
                      gap = 3, input bit bad = 1'b0);
      logic [7:0] f[$];
      logic [7:0] e[$];
      logic [7:0] code;
      logic [15:0] c;
      bit quiet;
      int seen;
      quiet = extra > 0 || err_at >= 0 || gap > 24 || bad || (ad != my_addr && ad != 8'h00);
      f = '{ad, fn, st[15:8], st[7:0], q[15:8], q[7:0]};
      if (fn == FN_WRITE)
         f.push_back(bc);
      for (int i = 0; i < bc && fn == FN_WRITE; i++)
         f.push_back(i[0] ? w[7:0] : w[15:8]);
      repeat (extra) f.push_back(8'h5A);
      c = crc16(f) ^ {15'h0000, bad};
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      i_serial_master_model.got.delete();
      i_serial_master_model.send(f, err_at, gap);
      // Drive state lands after set_state's edge, so the expectation waits for it
      code = exp_code(fn, st, q, w, bc, ad == BCAST_ADDR);
      seen = 0;
      repeat (40) begin
         #1;
         if (cmd_ok === 1'b1) begin
            seen++;
            check_val({8'h00, cmd_func}, {8'h00, fn}, "cmd_func");
            check_val(cmd_start, st, "cmd_start");
            check_val(cmd_qty, q, "cmd_qty");
            check_val({15'h0000, cmd_bcast}, {15'h0000, ad == BCAST_ADDR}, "cmd_bcast");
         end
         @(posedge clk);
      end
      check_val(16'(seen), {15'h0000, !quiet && code == ERR_NONE}, "accept count");
      // Word address stops one past the last word received
      if (fn == FN_WRITE)
         check_val(lim_addr, st + 16'(bc >> 1), "lim_addr");
      if (!quiet && code != ERR_NONE && ad != BCAST_ADDR) begin
         e = '{ad, fn | EXC_FLAG, code};
         c = crc16(e);
         e.push_back(c[7:0]);
         e.push_back(c[15:8]);
      end
      check_val(16'(i_serial_master_model.got.size()), 16'(e.size()), "reply length");
      foreach (e[i]) check_val({8'h00, i_serial_master_model.got[i]}, {8'h00, e[i]}, "reply");
   endtask

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #240000;
      fail_count++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      finish_test();
   end

   initial begin
      logic [7:0] fns[4];
      logic [15:0] q;
      fns = '{FN_READ, FN_WRITE, FN_LOOP, 8'h42};
      void'($urandom(32'hEAC2));
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      foreach (bad_fn[i]) run(my_addr, bad_fn[i], 16'h0001, 16'h0001);
      run(my_addr, FN_LOOP, 16'h1234, 16'h5678);
      $display("test function done");
      run(my_addr, FN_READ, 16'h0040, 16'h0001);
      run(my_addr, FN_READ, 16'h003F, 16'h0002);
      run(my_addr, FN_READ, 16'h0900, 16'h0001);
      run(my_addr, FN_READ, 16'h0910, 16'h0001);
      run(my_addr, FN_READ, 16'h0005, 16'h0010);
      run(my_addr, FN_READ, 16'h0001, 16'h0000);
      run(my_addr, FN_READ, 16'h0001, 16'h0011);
      run(my_addr, FN_WRITE, 16'h0001, 16'h0002, 16'h0FFF, 8'h03);
      run(my_addr, FN_WRITE, 16'h0001, 16'h0002, 16'h0FFF, 8'h04);
      run(my_addr, FN_WRITE, 16'h0001, 16'h0001, 16'h1000);
      run(my_addr, FN_WRITE, 16'h000F, 16'h0002, 16'h0001, 8'h04);
      $display("test address and count done");
      set_state(0, 0, 0, 0, 0, 16'h0FFF);
      run(my_addr, FN_WRITE, 16'h0100, 16'h0001);
      set_state(0, 0, 0, 0, 1, 16'h0FFF, 16'h0010);
      run(my_addr, FN_WRITE, 16'h0001, 16'h0001, 16'h000F);
      run(my_addr, FN_WRITE, 16'h0001, 16'h0001, 16'h0010);
      set_state(1, 0, 0, 0, 1, 16'h0FFF);
      run(my_addr, FN_WRITE, 16'h0100, 16'h0001);
      run(my_addr, FN_WRITE, 16'h0900, 16'h0001, 16'h0000);
      run(my_addr, FN_WRITE, 16'h0001, 16'h0001);
      set_state(0, 1, 0, 0, 1, 16'h0FFF);
      run(my_addr, FN_WRITE, 16'h0910, 16'h0001, 16'h0000);
      run(my_addr, FN_WRITE, 16'h0200, 16'h0001);
      set_state(0, 0, 1, 0, 1, 16'h0FFF);
      run(my_addr, FN_WRITE, 16'h0200, 16'h0001);
      run(my_addr, FN_WRITE, 16'h0101, 16'h0006, 16'h0005, 8'h0C);
      run(my_addr, FN_WRITE, 16'h0302, 16'h0001);
      set_state(0, 0, 0, 1, 1, 16'h0FFF);
      run(my_addr, FN_WRITE, 16'h0100, 16'h0001);
      run(my_addr, FN_WRITE, 16'h0001, 16'h0001);
      set_state(0, 0, 0, 0, 1, 16'h0FFF);
      $display("test write state done");
      run(8'h00, FN_WRITE, 16'h0003, 16'h0001);
      run(8'h00, FN_WRITE, 16'h0002, 16'h0001);
      run(my_addr, 8'h05, 16'h0001, 16'h0001, 16'h0005, 8'h02, 0, 3);
      run(my_addr, 8'h05, 16'h0001, 16'h0001, 16'h0005, 8'h02, 0, -1, 3, 1);
      run(my_addr, FN_READ, 16'h0001, 16'h0001, 16'h0005, 8'h02, 0, -1, 25);
      run(my_addr, FN_READ, 16'h0001, 16'h0001, 16'h0005, 8'h02, 0, -1, 24);
      run(my_addr, FN_READ, 16'h0001, 16'h0001, 16'h0005, 8'h02, 1);
      run(8'h20, FN_READ, 16'h0001, 16'h0001);
      $display("test discard done");
      repeat (40) begin
         set_state($urandom % 6 == 0, $urandom % 6 == 0, $urandom % 6 == 0, $urandom % 6 == 0,
                   $urandom % 6 != 0, 16'($urandom), 16'($urandom % 32));
         q = 16'($urandom % 18);
         run(($urandom % 8 == 0) ? 8'h00 : my_addr, fns[$urandom % 4],
             16'($urandom % 16'h0A00), q, 16'($urandom), 8'(2 * q + ($urandom % 8 == 0)),
             0, ($urandom % 16 == 0) ? 2 : -1, $urandom % 27);
      end
      $display("test random done");
      finish_test();
   end
endmodule // tb
